// file: design/dbs_defines.svh
`ifndef DBS_DEFINES_SVH
`define DBS_DEFINES_SVH

// ==========================================================
// size output codes
`define DBS_SIZE_BYTE 2'b01
`define DBS_SIZE_WORD 2'b10
`define DBS_SIZE_THREE 2'b11
`define DBS_SIZE_LONG 2'b00

// ==========================================================
// operand size requested on the internal port
`define DBS_OP_BYTE 2'b00
`define DBS_OP_WORD 2'b01
`define DBS_OP_LONG 2'b10

// ==========================================================
// buffering, widths and idle ack pattern
`define DBS_FIFO_DEPTH 8
`define DBS_FIFO_WIDTH 32
`define DBS_ADDR_WIDTH 24
`define DBS_ACK_IDLE 2'b11

`endif

// file: design/dbs_fifo.sv
`timescale 1ns/1ps
`include "dbs_defines.svh"

// read-result buffer, registered valid and pointers
module dbs_fifo
	import dbs_pkg::*;
#(
	parameter int WIDTH = `DBS_FIFO_WIDTH,
	parameter int DEPTH = `DBS_FIFO_DEPTH
)
(
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [PW-1:0] wptr;
		logic [PW-1:0] rptr;
		logic [CW-1:0] count;
		logic valid;
	} dbs_fifo_reg_type;

	dbs_fifo_reg_type cur;
	dbs_fifo_reg_type next_cur;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
		begin : g_bad
			$error("dbs_fifo: DEPTH must be a power of two >= 2");
		end
	endgenerate

	// ======================================================
	// pointer and count update
	assign o_in_ready = (cur.count != CW'(DEPTH));
	assign push = i_in_valid && o_in_ready;
	assign pop = cur.valid && i_out_ready;

	always_comb
	begin
		next_cur = cur;
		if (push)
			next_cur.wptr = cur.wptr + 1'b1;
		if (pop)
			next_cur.rptr = cur.rptr + 1'b1;
		if (push && !pop)
			next_cur.count = cur.count + 1'b1;
		else if (pop && !push)
			next_cur.count = cur.count - 1'b1;
		next_cur.valid = (next_cur.count != '0);
	end

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			cur <= '0;
		else
			cur <= next_cur;
	end

	// storage has no reset; valid guards every read
	always_ff @(posedge i_clock)
	begin
		if (push)
			mem[cur.wptr] <= i_in_data;
	end

	assign o_out_valid = cur.valid;
	assign o_out_data = mem[cur.rptr];

	// pointers and count must tell the same story, full included
	property p_fifo_count;
		@(posedge i_clock) disable iff (!i_rst_b)
		cur.count <= CW'(DEPTH) && cur.wptr - cur.rptr == PW'(cur.count);
	endproperty
	a_fifo_count: assert property (p_fifo_count)
		else $error("fifo count disagrees with pointers");

endmodule

// file: design/dbs_mux.sv
`timescale 1ns/1ps
`include "dbs_defines.svh"

// Behaviour
// - decode acks: none waits, 8-bit only ends 8-bit, 16 ends 16, both reserved
// - move the most data each cycle; a word cycle assumes 16-bit port
// - operand bytes go most significant first
// - size outputs show bytes still to move; fewer may actually move
// - upper address is word base, low bit is byte offset steering the mux
// - byte always aligned; word or long misaligned at odd address
// - at most one aligned word per cycle; long goes high word first
// - misaligned long runs as two misaligned words, each starting with word code
// - byte uses code 01; upper lane unless 16-bit port at odd address
// - three-byte code only during aligned long reduced to byte cycles
// - reads take only the lane chosen by size, low address bit and width
// - byte writes drive the same byte on both lanes
// - 8-bit ack on wider operand: take upper byte, count down, step, repeat
// - aligned word write: first byte upper lane, second byte lower lane
// - aligned word to 16-bit port is one cycle, high byte on upper lane
// - misaligned word to 16-bit: word code, odd address, byte on lower lane
// - long read is four cycles on 8-bit port; on 16-bit port two when aligned, four at odd address
// - size codes 01 byte, 10 word, 11 three bytes, 00 long, valid with strobe
// - writes drive all sixteen lines; reads capture at cycle end
module dbs_mux
	import dbs_pkg::*;
#(
	parameter int FIFO_DEPTH = `DBS_FIFO_DEPTH
)
(
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_req_valid,
	output logic o_req_ready,
	input wire logic i_req_write,
	input wire logic [1:0] i_req_size,
	input wire logic [23:0] i_req_addr,
	input wire logic [31:0] i_req_wdata,
	output logic o_wr_done,
	output logic o_rd_valid,
	input wire logic i_rd_ready,
	output logic [31:0] o_rd_data,
	output logic [23:0] o_addr,
	output logic o_xfer_size_hi,
	output logic o_xfer_size_lo,
	output logic o_strobe_n,
	output logic o_read,
	output logic [15:0] o_data_out,
	output logic o_data_oe,
	input wire logic [15:0] i_data_in,
	input wire logic i_ack_port8_n,
	input wire logic i_ack_port16_n
);

	typedef struct packed {
		dbs_state_type state;
		logic [23:0] addr;
		logic [2:0] seg;
		logic second;
		logic write;
		logic [1:0] opsz;
		logic [31:0] bytes;
		logic [31:0] acc;
		logic req_ready;
		logic strobe_n;
		logic rd;
		logic [1:0] size;
		logic [15:0] dout;
		logic data_oe;
		logic wr_done;
	} dbs_reg_type;

	dbs_reg_type cur;
	dbs_reg_type next_cur;
	logic [1:0] ack_n;
	logic ack8;
	logic ack16;
	logic acks_idle;
	logic fifo_push;
	logic fifo_ready;
	logic launch;
	logic [2:0] moved;
	logic [7:0] rd_byte;

	generate
		if (FIFO_DEPTH < 2)
		begin : g_bad
			$error("dbs_mux: FIFO_DEPTH must be at least 2");
		end
	endgenerate

	// ======================================================
	// acknowledge synchroniser, both start negated
	dbs_sync #(.WIDTH(2)) u_sync (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_async_n({i_ack_port16_n, i_ack_port8_n}),
		.o_sync_n(ack_n)
	);

	// reserved pair (both low) counts as no completion
	assign ack8 = (ack_n == 2'b10);
	assign ack16 = (ack_n == 2'b01);
	assign acks_idle = (ack_n == `DBS_ACK_IDLE);

	// ======================================================
	// read results wait here; a full buffer stalls completion
	dbs_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_in_valid(fifo_push),
		.o_in_ready(fifo_ready),
		.i_in_data(cur.acc),
		.o_out_valid(o_rd_valid),
		.i_out_ready(i_rd_ready),
		.o_out_data(o_rd_data)
	);

	assign fifo_push = (cur.state == ST_RECOVER) && acks_idle
		&& cur.seg == 3'd0 && !cur.second && !cur.write;

	// ======================================================
	// bytes moved on an acknowledged cycle and read lane choice
	always_comb
	begin
		moved = 3'd1;
		if (ack16 && !cur.addr[0] && cur.seg >= 3'd2)
			moved = 3'd2;
		rd_byte = i_data_in[15:8];
		if (ack16 && cur.addr[0])
			rd_byte = i_data_in[7:0];
	end

	// ======================================================
	// sequencer: one operand split into bus cycles
	always_comb
	begin
		next_cur = cur;
		next_cur.wr_done = 1'b0;
		launch = 1'b0;
		case (cur.state)
			ST_IDLE:
			begin
				next_cur.req_ready = 1'b1;
				if (i_req_valid && cur.req_ready)
				begin
					next_cur.req_ready = 1'b0;
					next_cur.addr = i_req_addr;
					next_cur.write = i_req_write;
					next_cur.opsz = i_req_size;
					next_cur.acc = '0;
					next_cur.second = 1'b0;
					// first byte sits at the top of the queue
					if (i_req_size == `DBS_OP_BYTE)
					begin
						next_cur.bytes = {i_req_wdata[7:0], 24'h0};
						next_cur.seg = 3'd1;
					end
					else if (i_req_size == `DBS_OP_WORD)
					begin
						next_cur.bytes = {i_req_wdata[15:0], 16'h0};
						next_cur.seg = 3'd2;
					end
					else
					begin
						next_cur.bytes = i_req_wdata;
						// odd long splits into two word segments
						next_cur.seg = i_req_addr[0] ? 3'd2 : 3'd4;
						next_cur.second = i_req_addr[0];
					end
					launch = 1'b1;
				end
			end
			ST_WAIT:
			begin
				// outputs hold while no valid completion is seen
				if (ack8 || ack16)
				begin
					if (moved == 3'd2)
						next_cur.acc = {cur.acc[15:0], i_data_in};
					else
						next_cur.acc = {cur.acc[23:0], rd_byte};
					if (moved == 3'd2)
						next_cur.bytes = {cur.bytes[15:0], 16'h0};
					else
						next_cur.bytes = {cur.bytes[23:0], 8'h0};
					next_cur.seg = cur.seg - moved;
					next_cur.addr = cur.addr + 24'(moved);
					next_cur.strobe_n = 1'b1;
					next_cur.data_oe = 1'b0;
					next_cur.state = ST_RECOVER;
				end
			end
			ST_RECOVER:
			begin
				// next cycle only once the device released its acks
				if (acks_idle)
				begin
					if (cur.seg != 3'd0)
						launch = 1'b1;
					else if (cur.second)
					begin
						next_cur.seg = 3'd2;
						next_cur.second = 1'b0;
						launch = 1'b1;
					end
					else if (cur.write)
					begin
						next_cur.wr_done = 1'b1;
						next_cur.state = ST_IDLE;
						next_cur.req_ready = 1'b1;
					end
					else if (fifo_ready)
					begin
						next_cur.state = ST_IDLE;
						next_cur.req_ready = 1'b1;
					end
				end
			end
			default:
			begin
				next_cur.state = ST_IDLE;
			end
		endcase
		// start a bus cycle from the updated segment state
		if (launch)
		begin
			next_cur.size = dbs_size_code(next_cur.seg);
			next_cur.dout = dbs_lanes(next_cur.bytes, next_cur.seg,
				next_cur.addr[0]);
			next_cur.data_oe = next_cur.write;
			next_cur.rd = !next_cur.write;
			next_cur.strobe_n = 1'b0;
			next_cur.state = ST_WAIT;
		end
	end

	// ======================================================
	// state register
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cur <= '0;
			cur.strobe_n <= 1'b1;
			cur.rd <= 1'b1;
			cur.size <= `DBS_SIZE_BYTE;
		end
		else
			cur <= next_cur;
	end

	assign o_req_ready = cur.req_ready;
	assign o_wr_done = cur.wr_done;
	assign o_addr = cur.addr;
	assign o_xfer_size_hi = cur.size[1];
	assign o_xfer_size_lo = cur.size[0];
	assign o_strobe_n = cur.strobe_n;
	assign o_read = cur.rd;
	assign o_data_out = cur.dout;
	assign o_data_oe = cur.data_oe;

	// ======================================================
	// checks
	property p_hold_wait;
		@(posedge i_clock) disable iff (!i_rst_b)
		cur.state == ST_WAIT && acks_idle |=> !o_strobe_n
			&& $stable(o_addr) && $stable(cur.size) && $stable(o_data_out);
	endproperty
	a_hold_wait: assert property (p_hold_wait)
		else $error("bus outputs moved during wait");

	property p_reserved;
		@(posedge i_clock) disable iff (!i_rst_b)
		cur.state == ST_WAIT && ack_n == 2'b00 |=> cur.state == ST_WAIT;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved ack ended a cycle");

	property p_size_code;
		@(posedge i_clock) disable iff (!i_rst_b)
		!o_strobe_n |-> cur.size == dbs_size_code(cur.seg);
	endproperty
	a_size_code: assert property (p_size_code)
		else $error("size code does not match remaining bytes");

	property p_three_byte;
		@(posedge i_clock) disable iff (!i_rst_b)
		!o_strobe_n && cur.size == `DBS_SIZE_THREE
			|-> cur.opsz == `DBS_OP_LONG && !cur.second;
	endproperty
	a_three_byte: assert property (p_three_byte)
		else $error("three-byte code outside aligned long");

	property p_first_code;
		@(posedge i_clock) disable iff (!i_rst_b)
		cur.state == ST_IDLE && i_req_valid && o_req_ready
			&& i_req_size != `DBS_OP_BYTE
		|=> cur.size == ((cur.opsz == `DBS_OP_LONG && !cur.addr[0])
			? `DBS_SIZE_LONG : `DBS_SIZE_WORD);
	endproperty
	a_first_code: assert property (p_first_code)
		else $error("wrong first size code");

	property p_word_step;
		@(posedge i_clock) disable iff (!i_rst_b)
		cur.state == ST_WAIT && ack16 && !cur.addr[0] && cur.seg >= 3'd2
		|=> o_addr == $past(o_addr) + 24'd2 && cur.seg == $past(cur.seg) - 3'd2;
	endproperty
	a_word_step: assert property (p_word_step)
		else $error("aligned 16-bit cycle did not move a word");

	property p_byte_step;
		@(posedge i_clock) disable iff (!i_rst_b)
		cur.state == ST_WAIT && ack8
		|=> o_addr == $past(o_addr) + 24'd1 && cur.seg == $past(cur.seg) - 3'd1
			##1 o_strobe_n;
	endproperty
	a_byte_step: assert property (p_byte_step)
		else $error("8-bit ack did not step one byte");

	property p_dup_lanes;
		@(posedge i_clock) disable iff (!i_rst_b)
		!o_strobe_n && o_data_oe && (o_addr[0] || cur.seg == 3'd1)
		|-> o_data_out[15:8] == o_data_out[7:0];
	endproperty
	a_dup_lanes: assert property (p_dup_lanes)
		else $error("byte not duplicated on both lanes");

	property p_msb_first;
		@(posedge i_clock) disable iff (!i_rst_b)
		!o_strobe_n && o_data_oe |-> o_data_out[15:8] == cur.bytes[31:24]
			&& o_data_oe == !o_read;
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("upper lane is not the next operand byte");

	cover property (@(posedge i_clock) disable iff (!i_rst_b)
		!o_strobe_n && cur.size == `DBS_SIZE_THREE);
	cover property (@(posedge i_clock) disable iff (!i_rst_b)
		cur.state == ST_RECOVER && cur.second && acks_idle);
	cover property (@(posedge i_clock) disable iff (!i_rst_b)
		cur.state == ST_RECOVER && acks_idle && cur.seg == 3'd0
			&& !cur.write && !fifo_ready);

endmodule

// file: design/dbs_pkg.sv
`include "dbs_defines.svh"

package dbs_pkg;

	// ======================================================
	// bus cycle sequencer states
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_RECOVER = 2'b10
	} dbs_state_type;

	// ======================================================
	// size code for the bytes still to move in this segment
	function automatic logic [1:0] dbs_size_code(input logic [2:0] n);
		logic [1:0] code;
		code = `DBS_SIZE_LONG;
		if (n == 3'd1)
			code = `DBS_SIZE_BYTE;
		else if (n == 3'd2)
			code = `DBS_SIZE_WORD;
		else if (n == 3'd3)
			code = `DBS_SIZE_THREE;
		return code;
	endfunction

	// ======================================================
	// write lanes: next byte on upper, duplicate when alone or odd
	function automatic logic [15:0] dbs_lanes(input logic [31:0] b,
		input logic [2:0] n, input logic a0);
		logic [15:0] l;
		l = b[31:16];
		if (a0 || n == 3'd1)
			l = {b[31:24], b[31:24]};
		return l;
	endfunction

endpackage

// file: design/dbs_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser for active-low inputs, resets negated
module dbs_sync
	import dbs_pkg::*;
#(
	parameter int WIDTH = 2
)
(
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic [WIDTH-1:0] i_async_n,
	output logic [WIDTH-1:0] o_sync_n
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] safe;
	} dbs_sync_reg_type;

	dbs_sync_reg_type cur;
	dbs_sync_reg_type next_cur;

	generate
		if (WIDTH < 1)
		begin : g_bad
			$error("dbs_sync: WIDTH must be at least 1");
		end
	endgenerate

	// ======================================================
	// meta feeds only the second stage
	always_comb
	begin
		next_cur.meta = i_async_n;
		next_cur.safe = cur.meta;
	end

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			cur <= '1;
		else
			cur <= next_cur;
	end

	assign o_sync_n = cur.safe;

endmodule

// file: test/dbs_mem_model.sv
`timescale 1ns/1ps

// ==========================================
// far side: memory behind an 8 or 16 bit port
module dbs_mem_model
(
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_port16,
	input wire logic [3:0] i_wait,
	input wire logic i_reserved,
	input wire logic [23:0] i_addr,
	input wire logic i_size_hi,
	input wire logic i_size_lo,
	input wire logic i_strobe_n,
	input wire logic i_read,
	input wire logic [15:0] i_data_out,
	input wire logic i_data_oe,
	output logic [15:0] o_data_in,
	output logic o_ack_port8_n,
	output logic o_ack_port16_n
);
	logic [7:0] mem [256];
	logic [7:0] n_cycles, codes, cnt, a;
	logic [1:0] code;
	logic acked;
	logic [43:0] snap;
	int hold_bad, dup_bad;

	assign code = {i_size_hi, i_size_lo};
	assign a = i_addr[7:0];

	// known fill so untouched bytes read back predictably
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5c;
		hold_bad = 0;
		dup_bad = 0;
	end

	// one bus cycle per strobe; lanes toggle when not driven
	always @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_ack_port8_n <= 1'b1;
			o_ack_port16_n <= 1'b1;
			o_data_in <= 16'h5aa5;
			cnt <= 8'h00;
			acked <= 1'b0;
			n_cycles <= 8'h00;
			codes <= 8'h00;
		end
		else if (i_strobe_n)
		begin
			o_ack_port8_n <= 1'b1;
			o_ack_port16_n <= 1'b1;
			o_data_in <= ~o_data_in;
			cnt <= 8'h00;
			acked <= 1'b0;
		end
		else
		begin
			cnt <= cnt + 8'h01;
			// everything must stay put while we stall
			if (cnt == 8'h00)
				snap <= {i_addr, code, i_read, i_data_out, i_data_oe};
			else if (snap != {i_addr, code, i_read, i_data_out, i_data_oe})
				hold_bad++;
			if (!acked)
				o_data_in <= ~o_data_in;
			if (i_reserved && !acked)
			begin
				o_ack_port8_n <= 1'b0;
				o_ack_port16_n <= 1'b0;
			end
			else if (!acked && cnt >= {4'h0, i_wait})
			begin
				acked <= 1'b1;
				// width given every cycle, whatever the size
				o_ack_port8_n <= i_port16;
				o_ack_port16_n <= !i_port16;
				n_cycles <= n_cycles + 8'h01;
				codes <= {codes[5:0], code};
				if (i_read && i_port16)
					o_data_in <= {mem[{a[7:1], 1'b0}], mem[{a[7:1], 1'b1}]};
				else if (i_read)
					o_data_in <= {mem[a], ~mem[a]};
				else
				begin
					if (!i_data_oe)
						dup_bad++;
					if (code == 2'h1 && i_data_out[15:8] != i_data_out[7:0])
						dup_bad++;
					// an 8-bit port only sees the upper lane
					if (!i_port16 || !a[0])
						mem[a] <= i_data_out[15:8];
					else
						mem[a] <= i_data_out[7:0];
					if (i_port16 && !a[0] && code != 2'h1)
						mem[a + 8'h01] <= i_data_out[7:0];
				end
			end
		end
	end
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps

// ==========================================
// bench for the bus sizing block
module testbench;
	typedef struct packed
	{
		logic p16;
		logic [1:0] sz;
		logic [23:0] a;
		logic [31:0] d;
		logic [2:0] n;
		logic [7:0] codes;
	} dbs_row_type;

	logic clock, rst_b, req_valid, req_ready, req_write, wr_done;
	logic rd_valid, rd_ready, size_hi, size_lo, strobe_n, rd_dir;
	logic data_oe, ack8_n, ack16_n, port16, reserved;
	logic [1:0] req_size;
	logic [23:0] req_addr, addr;
	logic [31:0] req_wdata, rd_data;
	logic [15:0] data_out, data_in;
	logic [3:0] wait_n;
	logic [7:0] c0;
	int bad_count, compares;

	// size, alignment and port width cases with expected size codes
	dbs_row_type rows [11] = '{
		'{1'h0, 2'h0, 24'h11, 32'ha5, 3'h1, 8'h01},
		'{1'h1, 2'h0, 24'h20, 32'h3c, 3'h1, 8'h01},
		'{1'h1, 2'h0, 24'h21, 32'hc3, 3'h1, 8'h01},
		'{1'h0, 2'h1, 24'h30, 32'h1234, 3'h2, 8'h09},
		'{1'h0, 2'h1, 24'h41, 32'h5678, 3'h2, 8'h09},
		'{1'h1, 2'h1, 24'h50, 32'h9abc, 3'h1, 8'h02},
		'{1'h1, 2'h1, 24'h61, 32'hdef0, 3'h2, 8'h09},
		'{1'h0, 2'h2, 24'h70, 32'h01234567, 3'h4, 8'h39},
		'{1'h0, 2'h2, 24'h81, 32'h89abcdef, 3'h4, 8'h99},
		'{1'h1, 2'h2, 24'h90, 32'h13579bdf, 3'h2, 8'h02},
		'{1'h1, 2'h2, 24'ha1, 32'h2468ace0, 3'h4, 8'h99}
	};

	dbs_mux DUT
	(
		.i_clock(clock),
		.i_rst_b(rst_b),
		.i_req_valid(req_valid),
		.o_req_ready(req_ready),
		.i_req_write(req_write),
		.i_req_size(req_size),
		.i_req_addr(req_addr),
		.i_req_wdata(req_wdata),
		.o_wr_done(wr_done),
		.o_rd_valid(rd_valid),
		.i_rd_ready(rd_ready),
		.o_rd_data(rd_data),
		.o_addr(addr),
		.o_xfer_size_hi(size_hi),
		.o_xfer_size_lo(size_lo),
		.o_strobe_n(strobe_n),
		.o_read(rd_dir),
		.o_data_out(data_out),
		.o_data_oe(data_oe),
		.i_data_in(data_in),
		.i_ack_port8_n(ack8_n),
		.i_ack_port16_n(ack16_n)
	);

	dbs_mem_model mem_model
	(
		.i_clock(clock),
		.i_rst_b(rst_b),
		.i_port16(port16),
		.i_wait(wait_n),
		.i_reserved(reserved),
		.i_addr(addr),
		.i_size_hi(size_hi),
		.i_size_lo(size_lo),
		.i_strobe_n(strobe_n),
		.i_read(rd_dir),
		.i_data_out(data_out),
		.i_data_oe(data_oe),
		.o_data_in(data_in),
		.o_ack_port8_n(ack8_n),
		.o_ack_port16_n(ack16_n)
	);

	// ==========================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// hold the request until it is taken, then drop it
	task automatic issue(input logic wr, input logic [1:0] sz,
		input logic [23:0] a, input logic [31:0] d);
		int n;
		@(negedge clock);
		req_valid = 1'b1;
		req_write = wr;
		req_size = sz;
		req_addr = a;
		req_wdata = d;
		for (n = 0; n < 400; n++)
		begin
			@(posedge clock);
			if (req_ready === 1'b1)
				break;
		end
		// a request never taken is a failure, not a silent skip
		check(32'(n < 400), 32'h1);
		@(negedge clock);
		req_valid = 1'b0;
	endtask

	task automatic wait_flag(input logic want_rd);
		int n;
		for (n = 0; n < 400; n++)
		begin
			@(negedge clock);
			if ((want_rd ? rd_valid : wr_done) === 1'b1)
				break;
		end
		check(32'(n < 400), 32'h1);
	endtask

	task automatic pop(input logic [31:0] exp);
		wait_flag(1'b1);
		check(rd_data, exp);
		rd_ready = 1'b1;
		@(negedge clock);
		rd_ready = 1'b0;
	endtask

	// write then read back one row, counting cycles and codes
	task automatic run_row(input dbs_row_type r);
		logic [7:0] mask;
		int nb;
		port16 = r.p16;
		nb = (r.sz == 2'h0) ? 1 : ((r.sz == 2'h1) ? 2 : 4);
		mask = 8'hff >> (8 - 2 * r.n);
		for (int wr = 1; wr >= 0; wr--)
		begin
			c0 = mem_model.n_cycles;
			issue(wr[0], r.sz, r.a, r.d);
			if (wr == 1)
				wait_flag(1'b0);
			else
				pop(r.d);
			check(32'(mem_model.n_cycles - c0), 32'(r.n));
			check(32'(mem_model.codes & mask), 32'(r.codes));
		end
		for (int k = 0; k < nb; k++)
			check(32'(mem_model.mem[8'(r.a) + 8'(k)]),
				32'(r.d[8 * (nb - 1 - k) +: 8]));
	endtask

	// ==========================================
	// clock and watchdog
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial
	begin
		#300us;
		bad_count++;
		print_verdict();
	end

	// ==========================================
	// main sequence
	initial
	begin
		{bad_count, compares} = '0;
		{rst_b, req_valid, req_write, rd_ready, port16, reserved} = '0;
		{req_size, req_addr, req_wdata, wait_n} = '0;
		repeat (8) @(negedge clock);
		check(32'({strobe_n, data_oe, req_ready, rd_valid, wr_done,
			size_hi, size_lo}), 32'h41);
		rst_b = 1'b1;
		repeat (2) @(negedge clock);
		check(32'(req_ready), 32'h1);
		foreach (rows[i])
			run_row(rows[i]);
		// slow device: everything must hold through wait states
		wait_n = 4'h6;
		run_row('{1'h0, 2'h2, 24'hc0, 32'hfeedc0de, 3'h4, 8'h39});
		wait_n = 4'h0;
		// reserved ack pair must not end the cycle
		port16 = 1'b1;
		reserved = 1'b1;
		c0 = mem_model.n_cycles;
		issue(1'b1, 2'h1, 24'hd0, 32'h4321);
		repeat (10) @(negedge clock);
		check(32'(strobe_n), 32'h0);
		check(32'(mem_model.n_cycles - c0), 32'h0);
		reserved = 1'b0;
		wait_flag(1'b0);
		check(32'({mem_model.mem[8'hd0], mem_model.mem[8'hd1]}),
			32'h4321);
		// fill the result buffer with the consumer stalled, then drain
		port16 = 1'b0;
		for (int i = 0; i < 9; i++)
			issue(1'b0, 2'h0, 24'(i), 32'h0);
		repeat (30) @(negedge clock);
		check(32'({req_ready, rd_valid}), 32'h1);
		for (int i = 0; i < 9; i++)
			pop(32'(8'(i) ^ 8'h5c));
		repeat (4) @(negedge clock);
		check(32'(rd_valid), 32'h0);
		// reset in the middle of a stalled bus cycle, then recover
		wait_n = 4'hf;
		issue(1'b0, 2'h2, 24'h40, 32'h0);
		repeat (4) @(negedge clock);
		rst_b = 1'b0;
		@(negedge clock);
		check(32'({strobe_n, data_oe, req_ready, rd_valid, wr_done,
			size_hi, size_lo}), 32'h41);
		rst_b = 1'b1;
		wait_n = 4'h0;
		repeat (2) @(negedge clock);
		check(32'({req_ready, strobe_n}), 32'h3);
		issue(1'b0, 2'h0, 24'h11, 32'h0);
		pop(32'ha5);
		check(32'(mem_model.hold_bad), 32'h0);
		check(32'(mem_model.dup_bad), 32'h0);
		print_verdict();
	end
endmodule
